//--- dps_pkg.sv
// Constants and types shared by the distributor phase sequencer
package dps_pkg;
    localparam int          WORD_W      = 6;
    localparam int          STEP_W      = 5;
    localparam int          CLK_NS      = 50;
    localparam int          STEP_NS     = 50000;
    localparam int          STEP_CYC    = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0]  DS_0        = 5'h00;
    localparam logic [4:0]  DS_1        = 5'h01;
    localparam logic [4:0]  DS_2        = 5'h02;
    localparam logic [4:0]  DS_3        = 5'h03;
    localparam logic [4:0]  DS_4        = 5'h04;
    localparam logic [4:0]  DS_5        = 5'h05;
    localparam logic [4:0]  DS_6        = 5'h06;
    localparam logic [4:0]  DS_7        = 5'h07;
    localparam logic [4:0]  DS_12       = 5'h0c;
    localparam logic [4:0]  DS_13       = 5'h0d;
    localparam logic [4:0]  DS_15       = 5'h0f;
    localparam logic [4:0]  DS_16       = 5'h10;
    localparam logic [4:0]  DS_17       = 5'h11;
    localparam logic [1:0]  AC_IDLE     = 2'h0;
    localparam logic [1:0]  AC_T1       = 2'h1;
    localparam logic [1:0]  AC_T2       = 2'h2;
    localparam logic [1:0]  AC_T3       = 2'h3;
    localparam logic [5:0]  OP_MAN_IN   = 6'h10;
    localparam logic [5:0]  OP_MAN_OUT  = 6'h12;
    localparam logic [5:0]  OP_EXT_IN   = 6'h14;
    localparam logic [5:0]  OP_EXT_OUT  = 6'h16;
    localparam logic [5:0]  OP_LOAD     = 6'h20;
    localparam logic [5:0]  OP_ADD      = 6'h24;
    localparam logic [5:0]  OP_MUL      = 6'h2c;
    localparam logic [5:0]  OP_DIV      = 6'h2e;
    localparam logic [5:0]  OP_SHR      = 6'h34;
    localparam logic [5:0]  OP_SHL      = 6'h36;
    localparam logic [5:0]  OP_STOP     = 6'h3e;
    localparam logic [5:0]  WORD_RST    = 6'h00;
    localparam logic [5:0]  PC_INCR     = 6'h02;
    localparam logic [5:0]  LOOP_PRESET = 6'h3f;
    localparam logic [4:0]  MAG_ONES    = 5'h1f;
    typedef struct packed {
        logic sign;
        logic ovf;
        logic zero;
        logic ierr;
    } dps_flags_s;
    localparam dps_flags_s  FLAGS_RST   = '{sign: 1'b0, ovf: 1'b0, zero: 1'b0, ierr: 1'b0};
endpackage

//--- dps_sequencer.sv
// Distributor phase sequencer: acquisition, add execution and loop control
//
// Contract
// - Acquisition step 0 copies program counter into memory address register.
// - Acquisition step 1 reads instruction code from memory into exchange register.
// - Acquisition step 2 clears instruction register and instruction-error flag.
// - Acquisition step 3 moves exchange register into instruction register.
// - Acquisition step 4 checks the instruction code for legality.
// - Acquisition step 5 advances the program counter by two.
// - Acquisition step 12 sets address bit zero to fetch operand address word.
// - Acquisition step 13 reads operand address into exchange register.
// - Step 16 clears sign flag; in acquisition it also clears overflow and zero-result flags.
// - Acquisition step 17 loads operand address into address register, enters execution.
// - Add execution step 1 reads operand data into exchange register.
// - Add execution step 3 sets sign flag when operand signs differ.
// - Add execution step 4 complements operand magnitude when sign flag set.
// - Add execution step 5 hands timing to adder counter until it returns to zero.
// - Add execution step 6 complements accumulator when sign set, overflow and zero clear.
// - Execution step 17 toggles phase back to acquisition.
// - Stop instruction halts in execution with distributor at step 5.
// - Eight instructions use loop sequences: manual, external I/O, multiply, divide, shifts.
// - Loop repeats step group loop-counter times, then finishes through step 17.
// - Shift sets loop counter at step 0, loads shift count at step 2.
// - Shift loop tests counter zero at step 12, decrements at step 13.
// - Step 15 shifts pair; step 16 jumps to 7 while nonzero, else 17.
// - Distributor advances by exactly one after each ordinary step.
// - Adder counter advances by one each adder phase, phase 1 through 3, then wraps to 0.
module dps_sequencer #(
    parameter int STEP_CYCLES = dps_pkg::STEP_CYC
) (
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               run_pin,
    input  wire logic               clear_pin,
    input  wire logic [5:0]         mem_rdata,
    output logic [5:0]              mem_addr_q,
    output logic                    mem_rd_q,
    output logic [4:0]              distributor_step_q,
    output logic                    phase_toggle_q,
    output logic [1:0]              adder_step_counter_q,
    output logic [5:0]              pc_q,
    output logic [5:0]              xreg_q,
    output logic [5:0]              ireg_q,
    output logic [5:0]              areg_q,
    output logic [5:0]              qreg_q,
    output logic [5:0]              loop_cnt_q,
    output dps_pkg::dps_flags_s     flags_q,
    output logic                    halted_q
);

    function automatic logic is_loop_op(input logic [5:0] op);
        is_loop_op = (op == dps_pkg::OP_MAN_IN) || (op == dps_pkg::OP_MAN_OUT)
                  || (op == dps_pkg::OP_EXT_IN) || (op == dps_pkg::OP_EXT_OUT)
                  || (op == dps_pkg::OP_MUL)    || (op == dps_pkg::OP_DIV)
                  || (op == dps_pkg::OP_SHR)    || (op == dps_pkg::OP_SHL);
    endfunction

    function automatic logic is_legal_op(input logic [5:0] op);
        is_legal_op = is_loop_op(op) || (op == dps_pkg::OP_LOAD)
                   || (op == dps_pkg::OP_ADD) || (op == dps_pkg::OP_STOP);
    endfunction

    localparam int DIV_W = $clog2(STEP_CYCLES + 1);

    logic [1:0]       sync1_q;
    logic [1:0]       sync2_q;
    logic [DIV_W-1:0] div_q;
    logic             tick_q;
    logic             adder_busy_q;
    logic             loop_zero_q;
    logic             clr;
    logic             step_en;
    logic             acq;
    logic             exe;
    logic             op_add;
    logic             op_loop;
    logic             op_shift;
    logic [5:0]       sum;
    logic [4:0]       am_shift;

    // Panel pins pass two flip-flops before use
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
        end else begin
            sync1_q <= {clear_pin, run_pin};
            sync2_q <= sync1_q;
        end
    end

    assign clr      = sync2_q[1];
    assign acq      = !phase_toggle_q;
    assign exe      = phase_toggle_q;
    assign op_add   = (ireg_q == dps_pkg::OP_ADD);
    assign op_loop  = is_loop_op(ireg_q);
    assign op_shift = (ireg_q == dps_pkg::OP_SHR) || (ireg_q == dps_pkg::OP_SHL);
    // Distributor is frozen while the adder counter owns timing
    assign step_en  = tick_q && sync2_q[0] && !halted_q && !adder_busy_q;
    assign sum      = {1'b0, areg_q[4:0]} + {1'b0, xreg_q[4:0]};

    // Step rate divider: one enable pulse per distributor pulse
    always_ff @(posedge mclk) begin
        if (sys_rst || clr) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == DIV_W'(STEP_CYCLES - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + DIV_W'(1);
            tick_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || clr) begin
            distributor_step_q <= dps_pkg::DS_0;
        end else if (tick_q && adder_busy_q && adder_step_counter_q == dps_pkg::AC_T3) begin
            distributor_step_q <= dps_pkg::DS_6;
        end else if (step_en) begin
            if (exe && distributor_step_q == dps_pkg::DS_5 && ireg_q == dps_pkg::OP_STOP) begin
                distributor_step_q <= dps_pkg::DS_5;
            end else if (exe && distributor_step_q == dps_pkg::DS_5 && op_add) begin
                distributor_step_q <= dps_pkg::DS_5;
            end else if (exe && op_loop && distributor_step_q == dps_pkg::DS_16
                         && loop_cnt_q != dps_pkg::WORD_RST) begin
                distributor_step_q <= dps_pkg::DS_7;
            end else if (distributor_step_q == dps_pkg::DS_17) begin
                distributor_step_q <= dps_pkg::DS_0;
            end else begin
                distributor_step_q <= distributor_step_q + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || clr) begin
            phase_toggle_q <= 1'b0;
        end else if (step_en && distributor_step_q == dps_pkg::DS_17) begin
            phase_toggle_q <= !phase_toggle_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || clr) begin
            halted_q <= 1'b0;
        end else if (step_en && exe && distributor_step_q == dps_pkg::DS_5
                     && ireg_q == dps_pkg::OP_STOP) begin
            halted_q <= 1'b1;
        end
    end

    // Adder control counter: T1 at start, then one phase per pulse
    always_ff @(posedge mclk) begin
        if (sys_rst || clr) begin
            adder_busy_q         <= 1'b0;
            adder_step_counter_q <= dps_pkg::AC_IDLE;
        end else if (step_en && exe && op_add && distributor_step_q == dps_pkg::DS_5) begin
            adder_busy_q         <= 1'b1;
            adder_step_counter_q <= dps_pkg::AC_T1;
        end else if (tick_q && adder_busy_q) begin
            adder_step_counter_q <= adder_step_counter_q + 2'h1;
            if (adder_step_counter_q == dps_pkg::AC_T3) begin
                adder_busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pc_q <= dps_pkg::WORD_RST;
        end else if (step_en && acq && distributor_step_q == dps_pkg::DS_5) begin
            pc_q <= pc_q + dps_pkg::PC_INCR;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mem_addr_q <= dps_pkg::WORD_RST;
        end else if (step_en && acq) begin
            if (distributor_step_q == dps_pkg::DS_0) begin
                mem_addr_q <= pc_q;
            end else if (distributor_step_q == dps_pkg::DS_12) begin
                mem_addr_q[0] <= 1'b1;
            end else if (distributor_step_q == dps_pkg::DS_17) begin
                mem_addr_q <= xreg_q;
            end
        end
    end

    // Read strobe is registered: high for the clock after the pulse on which mem_rdata is taken
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mem_rd_q <= 1'b0;
        end else begin
            mem_rd_q <= step_en && ((acq && (distributor_step_q == dps_pkg::DS_1
                        || distributor_step_q == dps_pkg::DS_13))
                        || (exe && op_add && distributor_step_q == dps_pkg::DS_1));
        end
    end

    // Exchange register keeps the operand address into execution
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            xreg_q <= dps_pkg::WORD_RST;
        end else if (step_en) begin
            if (acq && (distributor_step_q == dps_pkg::DS_1
                        || distributor_step_q == dps_pkg::DS_13)) begin
                xreg_q <= mem_rdata;
            end else if (exe && op_add && distributor_step_q == dps_pkg::DS_1) begin
                xreg_q <= mem_rdata;
            end else if (exe && op_add && distributor_step_q == dps_pkg::DS_4 && flags_q.sign) begin
                xreg_q[4:0] <= ~xreg_q[4:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ireg_q <= dps_pkg::WORD_RST;
        end else if (step_en && acq) begin
            if (distributor_step_q == dps_pkg::DS_2) begin
                ireg_q <= dps_pkg::WORD_RST;
            end else if (distributor_step_q == dps_pkg::DS_3) begin
                ireg_q <= xreg_q;
            end
        end
    end

    // Accumulator: group carries folded into one add, carry kept for T2
    logic end_carry_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            areg_q      <= dps_pkg::WORD_RST;
            end_carry_q <= 1'b0;
        end else if (tick_q && adder_busy_q && adder_step_counter_q == dps_pkg::AC_T1) begin
            areg_q[4:0] <= sum[4:0];
            end_carry_q <= sum[5];
        end else if (step_en && exe && op_add && distributor_step_q == dps_pkg::DS_6
                     && flags_q.sign && !flags_q.ovf && !flags_q.zero) begin
            areg_q <= ~areg_q;
        end else if (step_en && exe && op_shift && distributor_step_q == dps_pkg::DS_15
                     && !loop_zero_q) begin
            areg_q[4:0] <= am_shift;
        end
    end

    // Loop counter and loop exit latch
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            loop_cnt_q  <= dps_pkg::WORD_RST;
            loop_zero_q <= 1'b0;
        end else if (step_en && exe && op_loop) begin
            if (distributor_step_q == dps_pkg::DS_0) begin
                loop_cnt_q <= dps_pkg::LOOP_PRESET;
            end else if (distributor_step_q == dps_pkg::DS_2) begin
                loop_cnt_q <= xreg_q;
            end else if (distributor_step_q == dps_pkg::DS_12) begin
                loop_zero_q <= (loop_cnt_q == dps_pkg::WORD_RST);
            end else if (distributor_step_q == dps_pkg::DS_13 && !loop_zero_q) begin
                loop_cnt_q <= loop_cnt_q - 6'h01;
            end
        end
    end

    // Pair shift: A magnitude and Q shift as one double register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            qreg_q <= dps_pkg::WORD_RST;
        end else if (tick_q && adder_busy_q) begin
            qreg_q <= qreg_q;
        end else if (step_en && exe && op_shift && distributor_step_q == dps_pkg::DS_15
                     && !loop_zero_q) begin
            if (ireg_q == dps_pkg::OP_SHR) begin
                qreg_q <= {1'b0, areg_q[0], qreg_q[4:1]};
            end else begin
                qreg_q <= {1'b0, qreg_q[3:0], 1'b0};
            end
        end
    end

    always_comb begin
        am_shift = areg_q[4:0];
        if (ireg_q == dps_pkg::OP_SHR) begin
            am_shift = {1'b0, areg_q[4:1]};
        end else begin
            am_shift = {areg_q[3:0], qreg_q[4]};
        end
    end

    // Flags: a hardware set in the same pulse wins over a clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_q <= dps_pkg::FLAGS_RST;
        end else begin
            if (step_en && acq && distributor_step_q == dps_pkg::DS_2) begin
                flags_q.ierr <= 1'b0;
            end else if (step_en && acq && distributor_step_q == dps_pkg::DS_4) begin
                flags_q.ierr <= !is_legal_op(ireg_q);
            end
            if (step_en && distributor_step_q == dps_pkg::DS_16) begin
                flags_q.sign <= 1'b0;
                if (acq) begin
                    flags_q.ovf  <= 1'b0;
                    flags_q.zero <= 1'b0;
                end
            end else if (step_en && exe && op_add && distributor_step_q == dps_pkg::DS_3
                         && areg_q[5] != xreg_q[5]) begin
                flags_q.sign <= 1'b1;
            end
            if (tick_q && adder_busy_q && adder_step_counter_q == dps_pkg::AC_T2 && end_carry_q) begin
                flags_q.ovf <= 1'b1;
            end
            if (tick_q && adder_busy_q && adder_step_counter_q == dps_pkg::AC_T3
                && areg_q[4:0] == dps_pkg::MAG_ONES) begin
                flags_q.zero <= 1'b1;
            end
        end
    end

    chk_step_order: assert property (@(posedge mclk) disable iff (sys_rst || clr)
        step_en && distributor_step_q == dps_pkg::DS_3 |=> distributor_step_q == dps_pkg::DS_4)
        else $error("distributor did not advance by one");
    chk_fetch_addr: assert property (@(posedge mclk) disable iff (sys_rst)
        step_en && acq && distributor_step_q == dps_pkg::DS_0 |=> mem_addr_q == $past(pc_q))
        else $error("program counter not copied to address");
    chk_pc_incr: assert property (@(posedge mclk) disable iff (sys_rst)
        step_en && acq && distributor_step_q == dps_pkg::DS_5 |=> pc_q == $past(pc_q) + 6'h02)
        else $error("program counter not advanced by two");
    chk_ireg_load: assert property (@(posedge mclk) disable iff (sys_rst)
        step_en && acq && distributor_step_q == dps_pkg::DS_3 |=> ireg_q == $past(xreg_q))
        else $error("instruction register not loaded");
    chk_phase_enter: assert property (@(posedge mclk) disable iff (sys_rst || clr)
        step_en && acq && distributor_step_q == dps_pkg::DS_17
        |=> exe && distributor_step_q == dps_pkg::DS_0 && mem_addr_q == $past(xreg_q))
        else $error("execution phase not entered");
    chk_adder_hold: assert property (@(posedge mclk) disable iff (sys_rst || clr)
        adder_busy_q |-> distributor_step_q == dps_pkg::DS_5)
        else $error("distributor moved during adder sequence");
    chk_adder_done: assert property (@(posedge mclk) disable iff (sys_rst || clr)
        $fell(adder_busy_q) && !$past(clr) |-> adder_step_counter_q == dps_pkg::AC_IDLE
        && distributor_step_q == dps_pkg::DS_6)
        else $error("adder did not return control at zero");
    chk_stop_halt: assert property (@(posedge mclk) disable iff (sys_rst || clr)
        halted_q |-> exe && distributor_step_q == dps_pkg::DS_5 ##1 halted_q)
        else $error("stop did not hold at step five");
    chk_loop_back: assert property (@(posedge mclk) disable iff (sys_rst || clr)
        step_en && exe && op_loop && distributor_step_q == dps_pkg::DS_16
        && loop_cnt_q != 6'h00 |=> distributor_step_q == dps_pkg::DS_7)
        else $error("loop did not return to step seven");
    chk_loop_dec: assert property (@(posedge mclk) disable iff (sys_rst)
        step_en && exe && op_loop && distributor_step_q == dps_pkg::DS_13 && !loop_zero_q
        |=> loop_cnt_q == $past(loop_cnt_q) - 6'h01)
        else $error("loop counter not decremented");
    chk_clear_seq: assert property (@(posedge mclk) disable iff (sys_rst)
        clr |=> distributor_step_q == dps_pkg::DS_0 && !phase_toggle_q)
        else $error("clear did not reset the sequence");

    cov_add_exec: cover property (@(posedge mclk) $fell(adder_busy_q));
    cov_loop_exit: cover property (@(posedge mclk) step_en && exe && op_loop
        && distributor_step_q == dps_pkg::DS_16 && loop_cnt_q == 6'h00);
    cov_stop: cover property (@(posedge mclk) $rose(halted_q));
    cov_ierr: cover property (@(posedge mclk) $rose(flags_q.ierr));

endmodule

//--- dps_mem_model.sv
// Core memory model answering reads at the sequencer's address register
module dps_mem_model (
    input  wire logic [5:0] mem_addr,
    output logic [5:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] words [64];
    // Same-clock read data, always driven for the addressed word
    assign mem_rdata = words[mem_addr];
endmodule

//--- distributor_phase_sequencer_bench.sv
// Testbench for the distributor phase sequencer
module distributor_phase_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                mclk;
    logic                sys_rst;
    logic                run_pin;
    logic                clear_pin;
    logic [5:0]          mem_rdata;
    logic [5:0]          mem_addr_q;
    logic                mem_rd_q;
    logic [4:0]          step;
    logic                phase;
    logic [1:0]          adc;
    logic [5:0]          pc_q;
    logic [5:0]          xreg_q;
    logic [5:0]          ireg_q;
    logic [5:0]          areg_q;
    logic [5:0]          qreg_q;
    logic [5:0]          loop_cnt_q;
    dps_pkg::dps_flags_s flags_q;
    logic                halted_q;
    logic [4:0]          prev_step;
    logic [5:0]          seq;
    int                  fails;
    int                  compares;
    int                  sevens;

    dps_sequencer #(.STEP_CYCLES(4)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .run_pin(run_pin), .clear_pin(clear_pin),
        .mem_rdata(mem_rdata), .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q),
        .distributor_step_q(step), .phase_toggle_q(phase), .adder_step_counter_q(adc),
        .pc_q(pc_q), .xreg_q(xreg_q), .ireg_q(ireg_q), .areg_q(areg_q), .qreg_q(qreg_q),
        .loop_cnt_q(loop_cnt_q), .flags_q(flags_q), .halted_q(halted_q)
    );
    dps_mem_model mem (.mem_addr(mem_addr_q), .mem_rdata(mem_rdata));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bounded wait for a given phase and step
    task automatic wait_at(input logic ph, input logic [4:0] st);
        int n;
        n = 0;
        while (!(phase === ph && step === st) && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        chk(n < 3000, 1'b1);
    endtask

    // Step order watch; wrap or clear may return to zero
    always @(negedge mclk) begin
        if (!sys_rst && step !== prev_step) begin
            chk((step == prev_step + 5'h01) || (prev_step == 5'h10 && step == 5'h07) || step == 5'h00, 1'b1);
            if (step == 5'h07 && phase) sevens++;
        end
        prev_step <= step;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        run_pin = 1'b0;
        clear_pin = 1'b0;
        fails = 0;
        compares = 0;
        sevens = 0;
        for (int i = 0; i < 64; i++) mem.words[i] = 6'h00;
        mem.words[0] = 6'h24;
        mem.words[1] = 6'h07;
        mem.words[2] = 6'h3e;
        mem.words[4] = 6'h34;
        mem.words[5] = 6'h05;
        mem.words[7] = 6'h25;
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        run_pin = 1'b1;
        chk({phase, step}, 6'h00);
        // Add: A holds +0, operand -5, sum -5
        wait_at(0, 5'h01); chk(mem_addr_q, 6'h00);
        wait_at(0, 5'h02); chk(xreg_q, 6'h24);
        chk(mem_rd_q, 1'b1);
        wait_at(0, 5'h03); chk(ireg_q, 6'h00);
        wait_at(0, 5'h04); chk(ireg_q, 6'h24);
        wait_at(0, 5'h05); chk(flags_q.ierr, 1'b0);
        wait_at(0, 5'h06); chk(pc_q, 6'h02);
        wait_at(0, 5'h0d); chk(mem_addr_q, 6'h01);
        wait_at(0, 5'h0e); chk(xreg_q, 6'h07);
        wait_at(0, 5'h11); chk({flags_q.sign, flags_q.ovf, flags_q.zero}, 3'h0);
        wait_at(1, 5'h00); chk({mem_addr_q, xreg_q}, {6'h07, 6'h07});
        wait_at(1, 5'h02); chk(xreg_q, 6'h25);
        wait_at(1, 5'h04); chk(flags_q.sign, 1'b1);
        wait_at(1, 5'h05); chk(xreg_q, 6'h3a);
        seq = 6'h00;
        for (int n = 0; n < 100 && step === 5'h05; n++) begin
            @(negedge mclk);
            if (step === 5'h05 && adc !== seq[1:0]) seq = {seq[3:0], adc};
        end
        chk(seq, 6'h1b);
        chk({step, adc}, {5'h06, 2'h0});
        wait_at(1, 5'h07); chk(areg_q, 6'h25);
        wait_at(1, 5'h11); chk(flags_q.sign, 1'b0);
        wait_at(0, 5'h00); chk(pc_q, 6'h02);
        $display("test add done");
        // Stop halts in execution at step 5
        wait_at(1, 5'h05);
        repeat (40) @(negedge mclk);
        chk({halted_q, phase, step}, {1'b1, 1'b1, 5'h05});
        $display("test stop done");
        // Clear leaves program counter alone
        clear_pin = 1'b1;
        repeat (4) @(negedge mclk);
        clear_pin = 1'b0;
        repeat (2) @(negedge mclk);
        chk({halted_q, phase, step, pc_q}, {7'h00, 6'h04});
        $display("test clear done");
        // Shift right five places over the A and Q pair
        sevens = 0;
        wait_at(0, 5'h01); chk(mem_addr_q, 6'h04);
        wait_at(0, 5'h03); chk(ireg_q, 6'h00);
        wait_at(1, 5'h01); chk(loop_cnt_q, 6'h3f);
        wait_at(1, 5'h03); chk(loop_cnt_q, 6'h05);
        wait_at(0, 5'h00);
        chk(sevens, 5);
        chk(loop_cnt_q, 6'h00);
        chk({areg_q, qreg_q}, {6'h20, 6'h05});
        $display("test shift done");
        finish_test();
    end
endmodule
